/* tb.sv */
// Self-checking bench for tbw_top: APB register tasks and core event pulses.
// Assumes a 100 MHz sys_clk; the sub clock pin is made here at sys_clk/16.
`timescale 1ns/10ps
`default_nettype none
module tb;
  import tbw_pkg::*;
  logic sys_clk, rst_n, psel, penable, pwrite, pready, pslverr, err, sub_clk_pin;
  logic svc_ack, svc_src, ret_and_enable, ret_plain, irq, irq_take, irq_take_src;
  logic stack_push, global_irq_enable, sleeping, wakeup;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata, rd;
  logic [PC_W-1:0]   core_pc, stack_pc;
  logic [3:0]        sub_div;
  int                num_errors, comparisons, cyc, n;
  time               t1;
  tbw_top u_tbw_top (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .sub_clk_pin(sub_clk_pin), .svc_ack(svc_ack), .svc_src(svc_src),
    .ret_and_enable(ret_and_enable), .ret_plain(ret_plain), .core_pc(core_pc), .irq(irq),
    .irq_take(irq_take), .irq_take_src(irq_take_src), .stack_push(stack_push),
    .stack_pc(stack_pc), .global_irq_enable(global_irq_enable), .sleeping(sleeping),
    .wakeup(wakeup));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task finish_test;
    if (num_errors == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Whole run is about 80k cycles, the longest wait being two 2^15 periods
  always @(posedge sys_clk) begin
    sub_div <= sub_div + 4'h1;
    sub_clk_pin <= sub_div[3];
    cyc <= cyc + 1;
    if (cyc == 99000) begin
      num_errors++;
      finish_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk({31'h0, pready}, 32'h1, "no ready");
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic eerr);
    apb(1'b0, a, 32'h0);
    chk(rd, exp, "read data");
    chk({31'h0, err}, {31'h0, eerr}, "error response");
  endtask
  task automatic wait_irq;
    n = 0;
    // Sample on the falling edge so the flag launched at the rising edge has settled
    do begin
      @(negedge sys_clk);
      n++;
    end while (irq !== 1'b1 && n < 40000);
    chk({31'h0, irq}, 32'h1, "irq did not rise");
  endtask
  // Time between two flags, so the enable-to-first-tick latency does not matter
  task automatic period(input logic [7:0] ctl, input logic [1:0] src, input logic [2:0] code,
                        input logic [1:0] m, input int exp);
    apb(1'b1, OFS_PRESCALER_CONTROL, {30'h0, src});
    apb(1'b1, OFS_IRQ_ENABLE, {30'h0, m});
    apb(1'b1, ctl, {24'h0, 5'h10, code});
    wait_irq();
    t1 = $time;
    apb(1'b1, OFS_IRQ_CLEAR, {30'h0, m});
    wait_irq();
    chk(32'(($time - t1) / 10), exp, "period");
    apb(1'b1, ctl, 32'h0);
    apb(1'b1, OFS_IRQ_CLEAR, 32'h3);
  endtask
  task automatic ret(input logic en, input logic exp);
    @(posedge sys_clk);
    if (en)
      ret_and_enable <= 1'b1;
    else
      ret_plain <= 1'b1;
    @(posedge sys_clk);
    ret_and_enable <= 1'b0;
    ret_plain <= 1'b0;
    #1;
    chk({31'h0, global_irq_enable}, {31'h0, exp}, "global enable after return");
  endtask
  initial begin
    {psel, penable, pwrite, svc_ack, svc_src, ret_and_enable, ret_plain} = 7'h0;
    {paddr, pwdata, core_pc, sub_div} = '0;
    {rst_n, sub_clk_pin, num_errors, comparisons, cyc} = '0;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i += 4) rdchk(8'(i), 32'h0, 1'b0);
    for (int i = 8; i < 32; i += 4) if (i != 16 && i != 24) rdchk(8'(i), 32'h0, 1'b0);
    apb(1'b1, OFS_TIME_BASE1_CONTROL, 32'hff);
    rdchk(OFS_TIME_BASE1_CONTROL, 32'h87, 1'b0);
    apb(1'b1, OFS_TIME_BASE1_CONTROL, 32'h0);
    rdchk(8'h20, 32'h0, 1'b1);
    apb(1'b1, OFS_IRQ_STATUS, 32'h1);
    chk({31'h0, err}, 32'h1, "status write refused");
    for (int c = 0; c < 3; c++) period(OFS_TIME_BASE0_CONTROL, 2'h0, 3'(c), 2'h1, 256 << c);
    period(OFS_TIME_BASE1_CONTROL, 2'h0, 3'h7, 2'h2, 32768);
    period(OFS_TIME_BASE0_CONTROL, 2'h1, 3'h0, 2'h1, 1024);
    period(OFS_TIME_BASE1_CONTROL, 2'h2, 3'h0, 2'h2, 4096);
    // Fastest source, so a divider that ran while off would flag within this wait
    apb(1'b1, OFS_PRESCALER_CONTROL, 32'h0);
    repeat (300) @(posedge sys_clk);
    rdchk(OFS_IRQ_STATUS, 32'h0, 1'b0);
    apb(1'b1, OFS_IRQ_ENABLE, 32'h0);
    apb(1'b1, OFS_IRQ_FORCE, 32'h1);
    repeat (20) @(posedge sys_clk);
    rdchk(OFS_IRQ_STATUS, 32'h1, 1'b0);
    chk({31'h0, irq}, 32'h0, "irq while disabled");
    apb(1'b1, OFS_IRQ_CLEAR, 32'h1);
    apb(1'b1, OFS_IRQ_FORCE, 32'h2);
    apb(1'b1, OFS_IRQ_ENABLE, 32'h3);
    apb(1'b1, OFS_CORE_CONTROL, 32'h1);
    #1;
    chk({30'h0, irq_take, irq_take_src}, 32'h3, "take source");
    @(posedge sys_clk);
    svc_ack <= 1'b1;
    svc_src <= 1'b1;
    core_pc <= 13'h1a5;
    @(posedge sys_clk);
    svc_ack <= 1'b0;
    #1;
    chk({18'h0, stack_push, stack_pc}, {19'h1, 13'h1a5}, "pc push");
    chk({31'h0, global_irq_enable}, 32'h0, "enable after service");
    rdchk(OFS_IRQ_STATUS, 32'h0, 1'b0);
    ret(1'b0, 1'b0);
    ret(1'b1, 1'b1);
    ret(1'b0, 1'b1);
    apb(1'b1, OFS_IRQ_ENABLE, 32'h0);
    apb(1'b1, OFS_IRQ_FORCE, 32'h1);
    apb(1'b1, OFS_CORE_CONTROL, 32'h2);
    rdchk(OFS_CORE_CONTROL, 32'h2, 1'b0);
    apb(1'b1, OFS_IRQ_FORCE, 32'h1);
    repeat (10) @(posedge sys_clk);
    chk({31'h0, sleeping}, 32'h1, "woken by a flag already set");
    apb(1'b1, OFS_PRESCALER_CONTROL, 32'h0);
    apb(1'b1, OFS_TIME_BASE1_CONTROL, 32'h80);
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (wakeup !== 1'b1 && n < 400);
    chk({30'h0, wakeup, sleeping}, 32'h2, "wake on rising flag");
    finish_test();
  end
endmodule
bind tbw_top tbw_asserts u_tbw_asserts (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .svc_ack(svc_ack), .ret_and_enable(ret_and_enable),
  .ret_plain(ret_plain), .core_pc(core_pc), .irq(irq), .irq_take(irq_take),
  .stack_push(stack_push), .stack_pc(stack_pc), .global_irq_enable(global_irq_enable),
  .sleeping(sleeping), .wakeup(wakeup));
`default_nettype wire

/* tbw_asserts.sv */
// Concurrent checks on the time base block, seeing only the ports of tbw_top.
// Assumes one clock, sys_clk, and rst_n as asynchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none
module tbw_asserts (
  input wire logic                     sys_clk,
  input wire logic                     rst_n,
  input wire logic                     psel,
  input wire logic                     penable,
  input wire logic                     pwrite,
  input wire logic                     svc_ack,
  input wire logic                     ret_and_enable,
  input wire logic                     ret_plain,
  input wire logic [tbw_pkg::PC_W-1:0] core_pc,
  input wire logic                     irq,
  input wire logic                     irq_take,
  input wire logic                     stack_push,
  input wire logic [tbw_pkg::PC_W-1:0] stack_pc,
  input wire logic                     global_irq_enable,
  input wire logic                     sleeping,
  input wire logic                     wakeup
);
  import tbw_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // A register write in the same cycle may legally move the global enable
  wire apb_wr = psel && penable && pwrite;
  sequence push_seq;
    ##1 (stack_push && (stack_pc == $past(core_pc)));
  endsequence
  chk_push_after_svc: assert property (svc_ack |-> push_seq)
    else $error("stack push missing after service");
  chk_push_cause: assert property (stack_push |-> $past(svc_ack))
    else $error("stack push without service");
  chk_svc_gie: assert property (svc_ack && !ret_and_enable && !apb_wr |=> !global_irq_enable)
    else $error("global enable kept after service");
  chk_ret_gie: assert property (ret_and_enable && !apb_wr |=> global_irq_enable)
    else $error("global enable not set by return");
  chk_plain_ret: assert property (ret_plain && !ret_and_enable && !svc_ack && !apb_wr
    |=> $stable(global_irq_enable))
    else $error("plain return changed global enable");
  chk_wake_pulse: assert property (wakeup |-> $past(sleeping) && !sleeping)
    else $error("wake pulse without leaving sleep");
  chk_wake_once: assert property (wakeup |=> !wakeup)
    else $error("wake pulse longer than one cycle");
  chk_irq_take: assert property (irq_take == (irq && global_irq_enable))
    else $error("interrupt take not gated by global enable");
endmodule
`default_nettype wire

/* tbw_pkg.sv */
// Constants, register map and field layout of the time base and interrupt wake-up block.
// Assumes a 32-bit APB slave with each register on one aligned word.
// What this block does
// RULE1: Time base 0 period is 2^(8+code) prescaler ticks
// RULE2: Time base 1 period uses its own code
// RULE3: Bit 7 switches time base 1 on
// RULE4: Bits 6 to 3 read as zero
// RULE5: Any rising request flag ends sleep
// RULE6: Enable bits never gate wake-up
// RULE7: Request flags stay set until serviced/cleared
// RULE8: Interrupt entry pushes only the program counter
// RULE9: Return-and-enable sets the global enable
// RULE10: Plain return leaves the global enable alone
// RULE11: Prescaler source: system, system/4, sub clock
// RULE12: Each time base flags its own overflow
// RULE13: Servicing clears the flag and global enable
// RULE14: Disabled divider is cleared and held at zero, enabled runs continuously
package tbw_pkg;

  localparam int unsigned ADDR_W   = 8;
  localparam int unsigned NUM_SRC  = 2;
  localparam int unsigned CNT_W    = 15;
  localparam int unsigned PC_W     = 13;

  localparam logic [ADDR_W-1:0] OFS_PRESCALER_CONTROL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_TIME_BASE0_CONTROL = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_TIME_BASE1_CONTROL = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS        = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_IRQ_CLEAR         = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE        = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_IRQ_FORCE         = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_CORE_CONTROL      = 8'h1c;

  localparam int unsigned TB_ON_BIT    = 7;
  localparam int unsigned TB_SEL_LSB   = 0;
  localparam int unsigned TB_SEL_W     = 3;
  localparam int unsigned PSC_SEL_LSB  = 0;
  localparam int unsigned PSC_SEL_W    = 2;
  localparam int unsigned GIE_BIT      = 0;
  localparam int unsigned SLEEP_BIT    = 1;
  localparam int unsigned TB_BASE_EXP  = 8;

  localparam logic [7:0]  TB_CTRL_RST   = 8'h00;
  localparam logic [1:0]  PSC_SEL_RST   = 2'h0;
  localparam logic [1:0]  FLAGS_RST     = 2'h0;
  localparam logic [1:0]  ENABLE_RST    = 2'h0;
  localparam logic        GIE_RST       = 1'b0;
  localparam logic [1:0]  PSC_DIV4_LAST = 2'h3;

  localparam logic [1:0]  PSC_SRC_SYS   = 2'h0;
  localparam logic [1:0]  PSC_SRC_SYS4  = 2'h1;

  typedef enum logic [1:0] {
    TBW_PSC_SYS,
    TBW_PSC_SYS4,
    TBW_PSC_SUB
  } tbw_psc_src_t;

endpackage

/* tbw_tbase.sv */
// One time base divider: counts prescaler ticks and pulses at each period end.
// Assumes tick is a one-cycle strobe on sys_clk.
`timescale 1ns/10ps
`default_nettype none
module tbw_tbase #(
  parameter int unsigned CNT_W = tbw_pkg::CNT_W
) (
  input  wire logic                          sys_clk,
  input  wire logic                          rst_n,
  input  wire logic                          tick,
  input  wire logic                          tb_on,
  input  wire logic [tbw_pkg::TB_SEL_W-1:0]  period_sel,
  output logic                               overflow
);
  import tbw_pkg::*;

  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic [CNT_W-1:0] last_cnt;
  logic             at_end;

  // Last count value of a 2^(8+sel) period
  function automatic logic [CNT_W-1:0] period_last(input logic [TB_SEL_W-1:0] sel);
    logic [CNT_W:0] span;
    span = '0;
    span[TB_BASE_EXP + 32'(sel)] = 1'b1;
    period_last = CNT_W'(span - 1'b1);
  endfunction

  assign last_cnt = period_last(period_sel);  // RULE1 RULE2
  // Greater-or-equal so a shortened period mid-count still ends at once
  assign at_end   = (cnt_ff >= last_cnt);
  assign overflow = tb_on && tick && at_end;  // RULE12
  assign nxt_cnt  = !tb_on   ? '0 :          // RULE14
                    !tick    ? cnt_ff :
                    at_end   ? '0 :
                               cnt_ff + 1'b1;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

endmodule
`default_nettype wire

/* tbw_top.sv */
// Two time bases with prescaler, interrupt flags, wake-up and global enable control.
// Assumes an APB master on sys_clk and a CPU core that reports vector entry and returns.
//
// Our own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module tbw_top (
  input  wire logic                        sys_clk,
  input  wire logic                        rst_n,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [tbw_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [31:0]                 pwdata,
  output logic                             pready,
  output logic [31:0]                      prdata,
  output logic                             pslverr,
  input  wire logic                        sub_clk_pin,
  input  wire logic                        svc_ack,
  input  wire logic                        svc_src,
  input  wire logic                        ret_and_enable,
  input  wire logic                        ret_plain,
  input  wire logic [tbw_pkg::PC_W-1:0]    core_pc,
  output logic                             irq,
  output logic                             irq_take,
  output logic                             irq_take_src,
  output logic                             stack_push,
  output logic [tbw_pkg::PC_W-1:0]         stack_pc,
  output logic                             global_irq_enable,
  output logic                             sleeping,
  output logic                             wakeup
);
  import tbw_pkg::*;

  // Register state
  logic [PSC_SEL_W-1:0] prescaler_source_sel_ff;
  logic                 tbase0_on_ff;
  logic                 tbase1_on_ff;
  logic [TB_SEL_W-1:0]  tbase0_period_sel_ff;
  logic [TB_SEL_W-1:0]  tbase1_period_sel_ff;
  logic [NUM_SRC-1:0]   flags_ff;
  logic [NUM_SRC-1:0]   enable_ff;
  logic                 gie_ff;
  logic                 sleep_ff;
  logic                 wakeup_ff;
  logic                 stack_push_ff;
  logic [PC_W-1:0]      stack_pc_ff;
  logic [31:0]          prdata_ff;
  logic                 pslverr_ff;

  // Sub clock synchroniser and prescaler
  logic                 sub_s1_ff;
  logic                 sub_s2_ff;
  logic                 sub_s3_ff;
  logic                 sub_lvl_ff;
  logic [1:0]           div4_ff;

  // Next values
  logic [NUM_SRC-1:0]   nxt_flags;
  logic                 nxt_gie;
  logic                 nxt_sleep;
  logic                 nxt_sub_lvl;
  logic [1:0]           nxt_div4;
  logic [31:0]          nxt_prdata;

  // Bus decode
  wire                  setup_phase = psel && !penable;
  wire                  access_ok   = psel && penable;
  wire                  wr_en       = access_ok && pwrite && !pslverr_ff;
  wire                  hit_psc     = (paddr == OFS_PRESCALER_CONTROL);
  wire                  hit_tb0     = (paddr == OFS_TIME_BASE0_CONTROL);
  wire                  hit_tb1     = (paddr == OFS_TIME_BASE1_CONTROL);
  wire                  hit_stat    = (paddr == OFS_IRQ_STATUS);
  wire                  hit_clr     = (paddr == OFS_IRQ_CLEAR);
  wire                  hit_en      = (paddr == OFS_IRQ_ENABLE);
  wire                  hit_force   = (paddr == OFS_IRQ_FORCE);
  wire                  hit_core    = (paddr == OFS_CORE_CONTROL);
  wire                  hit_any     = hit_psc || hit_tb0 || hit_tb1 || hit_stat ||
                                      hit_clr || hit_en || hit_force || hit_core;
  // Status is read-only, clear and force are write-only
  wire                  bad_dir     = (hit_stat && pwrite) ||
                                      ((hit_clr || hit_force) && !pwrite);
  wire                  setup_err   = !hit_any || bad_dir;

  wire                  wr_psc      = wr_en && hit_psc;
  wire                  wr_tb0      = wr_en && hit_tb0;
  wire                  wr_tb1      = wr_en && hit_tb1;
  wire                  wr_clr      = wr_en && hit_clr;
  wire                  wr_en_reg   = wr_en && hit_en;
  wire                  wr_force    = wr_en && hit_force;
  wire                  wr_core     = wr_en && hit_core;

  // Prescaler tick
  wire                  sys4_tick   = (div4_ff == PSC_DIV4_LAST);
  wire                  sub_rise    = nxt_sub_lvl && !sub_lvl_ff;
  wire                  psc_tick;
  wire [NUM_SRC-1:0]    tb_ovf;

  // Interrupt sources
  wire [NUM_SRC-1:0]    sw_clear    = wr_clr   ? pwdata[NUM_SRC-1:0] : '0;
  wire [NUM_SRC-1:0]    sw_force    = wr_force ? pwdata[NUM_SRC-1:0] : '0;
  wire [NUM_SRC-1:0]    svc_clear;
  wire [NUM_SRC-1:0]    flag_rise;
  wire [NUM_SRC-1:0]    pending     = flags_ff & enable_ff;
  wire                  sel_src     = pending[0] ? 1'b0 : 1'b1;

  assign psc_tick = (prescaler_source_sel_ff == PSC_SRC_SYS)  ? 1'b1 :      // RULE11
                    (prescaler_source_sel_ff == PSC_SRC_SYS4) ? sys4_tick :
                                                                sub_rise;

  // A change on the sub clock pin counts once stages two and three agree
  assign nxt_sub_lvl = (sub_s2_ff == sub_s3_ff) ? sub_s3_ff : sub_lvl_ff;
  assign nxt_div4    = div4_ff + 2'h1;

  tbw_tbase #(
    .CNT_W (CNT_W)
  ) u_tbase0 (
    .sys_clk    (sys_clk),
    .rst_n      (rst_n),
    .tick       (psc_tick),
    .tb_on      (tbase0_on_ff),
    .period_sel (tbase0_period_sel_ff),
    .overflow   (tb_ovf[0])
  );

  tbw_tbase #(
    .CNT_W (CNT_W)
  ) u_tbase1 (
    .sys_clk    (sys_clk),
    .rst_n      (rst_n),
    .tick       (psc_tick),
    .tb_on      (tbase1_on_ff),                                             // RULE3
    .period_sel (tbase1_period_sel_ff),
    .overflow   (tb_ovf[1])
  );

  // Service acknowledge clears only the vectored source
  assign svc_clear = svc_ack ? (svc_src ? 2'b10 : 2'b01) : 2'b00;            // RULE13

  // Set beats any clear in the same cycle; enable bits never clear a flag
  assign nxt_flags = (flags_ff & ~sw_clear & ~svc_clear) | tb_ovf | sw_force; // RULE7 RULE12
  assign flag_rise = nxt_flags & ~flags_ff;

  // Global enable: service clears it, return-and-enable sets it, plain return keeps it
  assign nxt_gie = ret_and_enable ? 1'b1 :                                   // RULE9
                   svc_ack        ? 1'b0 :                                   // RULE13
                   wr_core        ? pwdata[GIE_BIT] :
                                    gie_ff;                                   // RULE10

  // Wake-up is ungated by enable bits; a flag already high cannot rise, so it can wake only after being cleared and set again
  assign nxt_sleep = (|flag_rise)                ? 1'b0 :                    // RULE5 RULE6
                     (wr_core && pwdata[SLEEP_BIT]) ? 1'b1 :
                                                   sleep_ff;

  assign nxt_prdata = !hit_any  ? 32'h0000_0000 :
                      hit_psc   ? {30'h0, prescaler_source_sel_ff} :
                      hit_tb0   ? {24'h0, tbase0_on_ff, 4'h0, tbase0_period_sel_ff} :
                      hit_tb1   ? {24'h0, tbase1_on_ff, 4'h0, tbase1_period_sel_ff} :  // RULE4
                      hit_stat  ? {30'h0, flags_ff} :
                      hit_en    ? {30'h0, enable_ff} :
                      hit_core  ? {30'h0, sleep_ff, gie_ff} :
                                  32'h0000_0000;

  assign pready            = 1'b1;
  assign prdata            = prdata_ff;
  assign pslverr           = access_ok && pslverr_ff;
  assign irq               = |pending;
  assign irq_take          = irq && gie_ff;
  assign irq_take_src      = sel_src;
  assign stack_push        = stack_push_ff;
  assign stack_pc          = stack_pc_ff;
  assign global_irq_enable = gie_ff;
  assign sleeping          = sleep_ff;
  assign wakeup            = wakeup_ff;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sub_s1_ff  <= 1'b0;
      sub_s2_ff  <= 1'b0;
      sub_s3_ff  <= 1'b0;
      sub_lvl_ff <= 1'b0;
      div4_ff    <= 2'h0;
    end else begin
      sub_s1_ff  <= sub_clk_pin;
      sub_s2_ff  <= sub_s1_ff;
      sub_s3_ff  <= sub_s2_ff;
      sub_lvl_ff <= nxt_sub_lvl;
      div4_ff    <= nxt_div4;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prescaler_source_sel_ff <= PSC_SEL_RST;
    end else if (wr_psc) begin
      prescaler_source_sel_ff <= pwdata[PSC_SEL_LSB +: PSC_SEL_W];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tbase0_on_ff         <= TB_CTRL_RST[TB_ON_BIT];
      tbase0_period_sel_ff <= TB_CTRL_RST[TB_SEL_LSB +: TB_SEL_W];
    end else if (wr_tb0) begin
      tbase0_on_ff         <= pwdata[TB_ON_BIT];
      tbase0_period_sel_ff <= pwdata[TB_SEL_LSB +: TB_SEL_W];                 // RULE1
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tbase1_on_ff         <= TB_CTRL_RST[TB_ON_BIT];                         // RULE3
      tbase1_period_sel_ff <= TB_CTRL_RST[TB_SEL_LSB +: TB_SEL_W];
    end else if (wr_tb1) begin
      tbase1_on_ff         <= pwdata[TB_ON_BIT];                              // RULE3
      tbase1_period_sel_ff <= pwdata[TB_SEL_LSB +: TB_SEL_W];                 // RULE2
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      enable_ff <= ENABLE_RST;
    end else if (wr_en_reg) begin
      enable_ff <= pwdata[NUM_SRC-1:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_ff  <= FLAGS_RST;
      gie_ff    <= GIE_RST;
      sleep_ff  <= 1'b0;
      wakeup_ff <= 1'b0;
    end else begin
      flags_ff  <= nxt_flags;
      gie_ff    <= nxt_gie;
      sleep_ff  <= nxt_sleep;
      wakeup_ff <= sleep_ff && (|flag_rise);                                  // RULE5
    end
  end

  // Only the program counter is saved on interrupt entry
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      stack_push_ff <= 1'b0;
      stack_pc_ff   <= '0;
    end else begin
      stack_push_ff <= svc_ack;                                               // RULE8
      if (svc_ack) begin
        stack_pc_ff <= core_pc;                                               // RULE8
      end
    end
  end

  // Read data and error are captured in the setup cycle so the access phase needs no wait
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_ff  <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else if (setup_phase) begin
      prdata_ff  <= pwrite ? 32'h0000_0000 : nxt_prdata;
      pslverr_ff <= setup_err;
    end
  end

endmodule
`default_nettype wire
